// file: verilog/aop_pkg.sv
package aop_pkg;

   // ------------------------------------------------------------
   // Port forms and pin roles
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_PAR18 = 2'h0;
   localparam logic [1:0] MODE_PAR16 = 2'h1;
   localparam logic [1:0] MODE_PAR8 = 2'h2;
   localparam logic [1:0] MODE_SERIAL = 2'h3;

   localparam int RESULT_W = 18;
   localparam int PIN_CODING = 0;
   localparam int PIN_WSEL_LO = 1;
   localparam int PIN_WSEL_HI = 2;
   localparam int PIN_ALWAYS_OUT = 3;
   localparam int PIN_DIV0 = 4;
   localparam int PIN_DIV1 = 5;
   localparam int PIN_CLK_SRC = 6;
   localparam int PIN_SYNC_POL = 7;
   localparam int PIN_SCLK_INV = 8;
   localparam int PIN_RDC = 9;
   localparam int PIN_SDOUT = 10;
   localparam int PIN_SCLK = 11;

   // Only the always-output pin drives during reset
   localparam logic [17:0] OE_N_RST = 18'h3fff7;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_RESULT = 12'h000;
   localparam logic [11:0] ADDR_CTRL = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam int CTRL_START_BIT = 0;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_CONV_LSB = 2;
   localparam int ST_MASTER_BIT = 5;
   localparam int ST_BUSY_BIT = 6;
   localparam int ST_WSEL_LSB = 7;
   localparam int ST_TWOS_BIT = 9;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCLK_HALF_NS = 50;
   localparam logic [7:0] SCLK_BASE_HALF_CYC =
      8'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CONV_NORMAL = 3'h1,
      CONV_WARP = 3'h2,
      CONV_WIDEBAND = 3'h4
   } aop_conv_e;

   typedef enum logic [2:0] {
      SER_IDLE = 3'h1,
      SER_MASTER = 3'h2,
      SER_SLAVE = 3'h4
   } aop_ser_e;

endpackage : aop_pkg

// file: verilog/aop_port.sv
// Contract
// [RL1] Two interface-select pins pick 18-bit, 16-bit, byte bus or serial port.
// [RL2] Mode 0 drives bit 0 on the coding pin; coding always straight binary.
// [RL3] Other modes: coding pin is input; low inverts MSB for two's complement.
// [RL4] Fast high and accurate-n high selects wideband fastest conversion mode.
// [RL5] Fast high and accurate-n low selects ordinary fastest conversion mode.
// [RL6] Host keeps a minimum conversion start rate in the fast modes.
// [RL7] Both selects low selects normal mode, accurate at any start rate.
// [RL8] Pin 1 outputs bit 1 in mode 0, else word-select input.
// [RL9] Pin 2 outputs bit 2 in mode 0, input in modes 1 and 2.
// [RL10] Pin 3 is always driven, carrying bit 3 in parallel modes.
// [RL11] Pins 4 and 5 output bits in parallel modes, divide inputs in serial.
// [RL12] In master read-after-convert, divide inputs slow the serial clock.
// [RL13] Other serial modes leave the divide pins undriven.
// [RL14] Serial with source-select low: master drives its serial clock out.
// [RL15] Serial with source-select high: slave, host clock gated by chip select.
// [RL16] Master sync polarity low gives active-high frame sync, high active-low.
// [RL17] Pins 6 to 8 output result bits in parallel modes, serial roles otherwise.
// [RL18] Host holds all selection pins static during operation.
`timescale 1ns/1ps
module aop_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] mode_sel_pin,
   input wire logic fast_mode_sel,
   input wire logic accurate_mode_sel_n,
   input wire logic chip_select_n,
   input wire logic [17:0] pin_in,
   output logic [17:0] pin_out,
   output logic [17:0] pin_oe_n,
   output logic frame_sync,
   output logic [2:0] conv_mode
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [17:0] pin_meta_reg;
   logic [17:0] pin_sync_reg;
   logic [1:0] mode_meta_reg;
   logic [1:0] mode_reg;
   logic [1:0] conv_meta_reg;
   logic [1:0] conv_sync_reg;
   logic cs_meta_reg;
   logic cs_sync_reg;
   logic cs_prev_reg;
   logic sclk_prev_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_reg <= 18'h00000;
         pin_sync_reg <= 18'h00000;
         mode_meta_reg <= 2'h0;
         mode_reg <= 2'h0;
         conv_meta_reg <= 2'h0;
         conv_sync_reg <= 2'h0;
         cs_meta_reg <= 1'h1;
         cs_sync_reg <= 1'h1;
         cs_prev_reg <= 1'h1;
         sclk_prev_reg <= 1'h0;
      end else begin
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
         mode_meta_reg <= mode_sel_pin;
         mode_reg <= mode_meta_reg;
         conv_meta_reg <= {fast_mode_sel, accurate_mode_sel_n};
         conv_sync_reg <= conv_meta_reg;
         cs_meta_reg <= chip_select_n;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
         sclk_prev_reg <= pin_sync_reg[aop_pkg::PIN_SCLK];
      end
   end

   // ------------------------------------------------------------
   // Decoded configuration
   // ------------------------------------------------------------
   logic is_serial;
   logic is_master;
   logic twos_comp;
   logic rdc_sel;
   logic sync_pol;
   logic sclk_inv;
   logic [1:0] div_sel;
   logic [7:0] half_cyc;

   assign is_serial = (mode_reg == aop_pkg::MODE_SERIAL); // RL1
   assign is_master = is_serial && !pin_sync_reg[aop_pkg::PIN_CLK_SRC]; // RL14 RL15
   // Mode 0 forces straight binary
   assign twos_comp = (mode_reg != aop_pkg::MODE_PAR18) &&
                      !pin_sync_reg[aop_pkg::PIN_CODING]; // RL2 RL3
   assign rdc_sel = pin_sync_reg[aop_pkg::PIN_RDC];
   assign sync_pol = pin_sync_reg[aop_pkg::PIN_SYNC_POL];
   assign sclk_inv = pin_sync_reg[aop_pkg::PIN_SCLK_INV];
   assign div_sel = {pin_sync_reg[aop_pkg::PIN_DIV1], pin_sync_reg[aop_pkg::PIN_DIV0]};
   // Division only slows the clock in read-after-convert
   assign half_cyc = rdc_sel ? aop_pkg::SCLK_BASE_HALF_CYC :
                     8'(aop_pkg::SCLK_BASE_HALF_CYC << div_sel); // RL12

   // ------------------------------------------------------------
   // Conversion mode
   // ------------------------------------------------------------
   aop_pkg::aop_conv_e conv_mode_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_mode_reg <= aop_pkg::CONV_NORMAL;
      end else begin
         unique case (conv_sync_reg)
            2'h3: conv_mode_reg <= aop_pkg::CONV_WIDEBAND; // RL4
            2'h2: conv_mode_reg <= aop_pkg::CONV_WARP; // RL5
            default: conv_mode_reg <= aop_pkg::CONV_NORMAL; // RL7
         endcase
      end
   end

   assign conv_mode = conv_mode_reg;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   logic [17:0] result_reg;
   logic [31:0] prdata_reg;
   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic start_req;
   logic [31:0] status_val;
   aop_pkg::aop_ser_e ser_state;

   assign mapped = (paddr == aop_pkg::ADDR_RESULT) || (paddr == aop_pkg::ADDR_CTRL) ||
                   (paddr == aop_pkg::ADDR_STATUS);
   assign wr_en = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign start_req = wr_en && (paddr == aop_pkg::ADDR_CTRL) && pstrb[0] &&
                      pwdata[aop_pkg::CTRL_START_BIT];
   assign pready = 1'h1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_reg;

   always_comb begin
      status_val = 32'h00000000;
      status_val[aop_pkg::ST_MODE_LSB +: 2] = mode_reg;
      status_val[aop_pkg::ST_CONV_LSB +: 3] = conv_mode_reg;
      status_val[aop_pkg::ST_MASTER_BIT] = is_master;
      status_val[aop_pkg::ST_BUSY_BIT] = (ser_state != aop_pkg::SER_IDLE);
      status_val[aop_pkg::ST_WSEL_LSB +: 2] = {pin_sync_reg[aop_pkg::PIN_WSEL_HI],
                                               pin_sync_reg[aop_pkg::PIN_WSEL_LO]};
      status_val[aop_pkg::ST_TWOS_BIT] = twos_comp;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= 18'h00000;
      end else if (wr_en && (paddr == aop_pkg::ADDR_RESULT)) begin
         if (pstrb[0]) begin
            result_reg[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            result_reg[15:8] <= pwdata[15:8];
         end
         if (pstrb[2]) begin
            result_reg[17:16] <= pwdata[17:16];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_setup) begin
         if (paddr == aop_pkg::ADDR_RESULT) begin
            prdata_reg <= {14'h0000, result_reg};
         end else if (paddr == aop_pkg::ADDR_STATUS) begin
            prdata_reg <= status_val;
         end else begin
            prdata_reg <= 32'h00000000;
         end
      end
   end

   // ------------------------------------------------------------
   // Serial engine
   // ------------------------------------------------------------
   logic [17:0] coded;
   logic [17:0] shift_reg;
   logic [4:0] bit_cnt_reg;
   logic [7:0] div_cnt_reg;
   logic sclk_reg;
   logic sclk_s;
   logic slave_edge;

   assign coded = result_reg ^ {twos_comp, 17'h00000}; // RL3
   assign sclk_s = pin_sync_reg[aop_pkg::PIN_SCLK];
   assign slave_edge = sclk_inv ? (sclk_prev_reg && !sclk_s) : (!sclk_prev_reg && sclk_s);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser_state <= aop_pkg::SER_IDLE;
         shift_reg <= 18'h00000;
         bit_cnt_reg <= 5'h00;
         div_cnt_reg <= 8'h00;
         sclk_reg <= 1'h0;
      end else begin
         unique case (ser_state)
            aop_pkg::SER_IDLE: begin
               sclk_reg <= 1'h0;
               if (start_req && is_master) begin
                  ser_state <= aop_pkg::SER_MASTER;
                  shift_reg <= coded;
                  bit_cnt_reg <= 5'(aop_pkg::RESULT_W - 1);
                  div_cnt_reg <= half_cyc - 8'h01;
               end else if (is_serial && !is_master && cs_prev_reg && !cs_sync_reg) begin
                  ser_state <= aop_pkg::SER_SLAVE; // RL15
                  shift_reg <= coded;
               end
            end
            aop_pkg::SER_MASTER: begin
               if (div_cnt_reg != 8'h00) begin
                  div_cnt_reg <= div_cnt_reg - 8'h01;
               end else begin
                  div_cnt_reg <= half_cyc - 8'h01; // RL12
                  sclk_reg <= !sclk_reg;
                  if (sclk_reg) begin
                     if (bit_cnt_reg == 5'h00) begin
                        ser_state <= aop_pkg::SER_IDLE;
                     end else begin
                        shift_reg <= {shift_reg[16:0], 1'h0};
                        bit_cnt_reg <= bit_cnt_reg - 5'h01;
                     end
                  end
               end
            end
            aop_pkg::SER_SLAVE: begin
               if (cs_sync_reg) begin
                  ser_state <= aop_pkg::SER_IDLE;
               end else if (slave_edge) begin
                  shift_reg <= {shift_reg[16:0], 1'h0}; // RL15
               end
            end
            default: begin
               ser_state <= aop_pkg::SER_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_sync <= 1'h0;
      end else begin
         frame_sync <= (ser_state == aop_pkg::SER_MASTER) ^ (is_master && sync_pol); // RL16
      end
   end

   // ------------------------------------------------------------
   // Pin multiplexer
   // ------------------------------------------------------------
   logic [17:0] drive_en;
   logic [17:0] out_val;

   always_comb begin
      drive_en = {18{!is_serial}}; // RL11 RL17
      drive_en[aop_pkg::PIN_CODING] = (mode_reg == aop_pkg::MODE_PAR18); // RL2 RL3
      drive_en[aop_pkg::PIN_WSEL_LO] = (mode_reg == aop_pkg::MODE_PAR18); // RL8
      drive_en[aop_pkg::PIN_WSEL_HI] = (mode_reg == aop_pkg::MODE_PAR18); // RL9
      drive_en[aop_pkg::PIN_ALWAYS_OUT] = 1'h1; // RL10
      drive_en[aop_pkg::PIN_SDOUT] = 1'h1;
      drive_en[aop_pkg::PIN_SCLK] = !is_serial || is_master; // RL14 RL15
      // Divide pins are inputs in master read-after-convert, undriven in the other serial modes
      if (is_serial) begin
         drive_en[aop_pkg::PIN_DIV0] = 1'h0; // RL13
         drive_en[aop_pkg::PIN_DIV1] = 1'h0; // RL13
      end
   end

   always_comb begin
      out_val = coded;
      if (is_serial) begin
         out_val = 18'h00000;
         out_val[aop_pkg::PIN_SDOUT] = shift_reg[17];
         out_val[aop_pkg::PIN_SCLK] = sclk_reg; // RL14
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < aop_pkg::RESULT_W; gi++) begin : g_pin
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_out[gi] <= 1'h0;
               pin_oe_n[gi] <= aop_pkg::OE_N_RST[gi];
            end else begin
               pin_out[gi] <= out_val[gi];
               pin_oe_n[gi] <= !drive_en[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   logic [7:0] hi_cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt_reg <= 8'h00;
      end else begin
         hi_cnt_reg <= sclk_reg ? 8'(hi_cnt_reg + 8'h01) : 8'h00;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_MODE_SERIAL_PINS: assert property ( // RL1
      is_serial |=> pin_oe_n[aop_pkg::PIN_CLK_SRC] && pin_oe_n[aop_pkg::PIN_RDC])
      else $error("serial role pins driven in serial mode");
   AST_PIN0_MODE0: assert property ( // RL2
      (mode_reg == aop_pkg::MODE_PAR18) |=> !pin_oe_n[0] &&
      (pin_out[17] == $past(result_reg[17])))
      else $error("mode 0 bit 0 not driven or coding not straight");
   AST_TWOS_COMP: assert property ( // RL3
      (mode_reg == aop_pkg::MODE_PAR16) && !pin_sync_reg[0] |=>
      pin_oe_n[0] && (pin_out[17] == !$past(result_reg[17])))
      else $error("msb not inverted for two's complement");
   AST_WIDEBAND: assert property ( // RL4
      (conv_sync_reg == 2'h3) |=> (conv_mode == aop_pkg::CONV_WIDEBAND))
      else $error("wideband mode not selected");
   AST_WARP: assert property ( // RL5
      (conv_sync_reg == 2'h2) |=> (conv_mode == aop_pkg::CONV_WARP))
      else $error("fast mode not selected");
   AST_NORMAL: assert property ( // RL7
      (conv_sync_reg == 2'h0) |=> (conv_mode == aop_pkg::CONV_NORMAL))
      else $error("normal mode not selected");
   AST_PIN1_INPUT: assert property ( // RL8
      (mode_reg != aop_pkg::MODE_PAR18) |=> pin_oe_n[1])
      else $error("word select low pin driven");
   AST_PIN2_INPUT: assert property ( // RL9
      (mode_reg == aop_pkg::MODE_PAR16) || (mode_reg == aop_pkg::MODE_PAR8) |=> pin_oe_n[2])
      else $error("word select high pin driven");
   AST_PIN3_DRIVEN: assert property ( // RL10
      !pin_oe_n[3])
      else $error("bit 3 pin not driven");
   AST_DIV_PINS: assert property ( // RL11
      is_serial |=> pin_oe_n[4] && pin_oe_n[5])
      else $error("divide pins driven in serial mode");
   AST_DIV_HALF: assert property ( // RL12
      $fell(sclk_reg) && ($past(ser_state) == aop_pkg::SER_MASTER) |->
      (hi_cnt_reg == $past(half_cyc)))
      else $error("serial clock high phase wrong length");
   AST_DIV_HIZ_SLAVE: assert property ( // RL13
      is_serial && !is_master ##1 is_serial |-> pin_oe_n[4] && pin_oe_n[5])
      else $error("divide pins not high impedance");
   AST_MASTER_SCLK: assert property ( // RL14
      is_master |=> !pin_oe_n[11] && (pin_out[11] == $past(sclk_reg)))
      else $error("master serial clock not driven");
   AST_SLAVE_SCLK: assert property ( // RL15
      is_serial && !is_master |=> pin_oe_n[11])
      else $error("slave drives serial clock");
   AST_SYNC_POL: assert property ( // RL16
      (ser_state == aop_pkg::SER_MASTER) && is_master |=> (frame_sync == !$past(sync_pol)))
      else $error("frame sync polarity wrong");
   AST_PAR_BITS: assert property ( // RL17
      !is_serial |=> !pin_oe_n[8] && (pin_out[8:6] == $past(coded[8:6])))
      else $error("parallel bits 6 to 8 wrong");

   COV_MASTER: cover property (start_req && is_master ##1 ser_state == aop_pkg::SER_MASTER);
   COV_SLAVE: cover property ((ser_state == aop_pkg::SER_SLAVE) && slave_edge);
   COV_WIDEBAND: cover property (conv_mode == aop_pkg::CONV_WIDEBAND);
   COV_MODE0: cover property (mode_reg == aop_pkg::MODE_PAR18 && wr_en);

endmodule : aop_port

// file: tb/aop_host_model.sv
`timescale 1ns/1ps
module aop_host_model (
   input wire logic pclk,
   input wire logic [17:0] cfg,
   input wire logic [17:0] host_en,
   input wire logic [17:0] pin_out,
   input wire logic [17:0] pin_oe_n,
   input wire logic frame_sync,
   output logic [17:0] pin_in,
   output logic chip_select_n
);
   // ------------------------------------------------------------
   // Pin wires seen by the block
   // ------------------------------------------------------------
   logic sclk_q;
   logic tog;
   logic [17:0] hv;

   initial begin
      sclk_q = 1'b0;
      tog = 1'b0;
      chip_select_n = 1'b1;
   end

   always @(posedge pclk) tog <= ~tog;

   // Host serial clock sits on the clock pin when the host owns it
   assign hv = {cfg[17:12], sclk_q, cfg[10:0]};
   // Pins nobody drives toggle so stale data never looks valid
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & host_en & hv)
      | (pin_oe_n & ~host_en & {18{tog}});

   // ------------------------------------------------------------
   // Serial transfers
   // ------------------------------------------------------------
   // Clock runs only inside the frame, gated by chip select
   // Inverted clock idles high, so its first edge in a pulse is the active one
   task automatic slave_read(input logic inv, output logic [17:0] d);
      int i;
      sclk_q = inv;
      #7;
      chip_select_n = 1'b0;
      #400;
      d[17] = pin_out[10];
      for (i = 16; i >= 0; i--) begin
         sclk_q = ~inv;
         #100;
         sclk_q = inv;
         #95;
         d[i] = pin_out[10];
         #5;
      end
      chip_select_n = 1'b1;
   endtask : slave_read

   // Takes data on each rising clock from the block; reports last period
   task automatic master_read(input logic pol, output logic [17:0] d, output int per,
      output int bad);
      int n;
      int t;
      int last;
      logic prev;
      n = 0;
      t = 0;
      last = 0;
      bad = 0;
      per = 0;
      prev = pin_out[11];
      while (n < 18 && t < 2000) begin
         @(posedge pclk);
         t++;
         if (n > 0 && frame_sync !== ~pol) bad++;
         if (pin_out[11] === 1'b1 && prev === 1'b0) begin
            d[17 - n] = pin_out[10];
            per = t - last;
            last = t;
            n++;
         end
         prev = pin_out[11];
      end
   endtask : master_read
endmodule : aop_host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] pstrb;
   logic [1:0] mode_sel_pin;
   logic fast_mode_sel, accurate_mode_sel_n, chip_select_n, frame_sync;
   logic [17:0] pin_in, pin_out, pin_oe_n, cfg, host_en;
   logic [2:0] conv_mode;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   aop_port uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mode_sel_pin(mode_sel_pin),
      .fast_mode_sel(fast_mode_sel), .accurate_mode_sel_n(accurate_mode_sel_n),
      .chip_select_n(chip_select_n), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .frame_sync(frame_sync), .conv_mode(conv_mode));

   aop_host_model host (.pclk(pclk), .cfg(cfg), .host_en(host_en), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .frame_sync(frame_sync), .pin_in(pin_in),
      .chip_select_n(chip_select_n));

   always #12.5 pclk = ~pclk;

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Configuration is only changed between scenarios and then left alone
   task automatic setup(input logic [1:0] m, input logic [17:0] c, input logic [17:0] en);
      mode_sel_pin <= m;
      cfg <= c;
      host_en <= en;
      repeat (8) @(posedge pclk);
   endtask : setup

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_conv();
      logic [2:0] ex;
      for (int i = 0; i < 4; i++) begin
         ex = (i == 2) ? 3'h2 : (i == 3) ? 3'h4 : 3'h1;
         fast_mode_sel <= i[1];
         accurate_mode_sel_n <= i[0];
         repeat (5) @(posedge pclk);
         chk(32'(conv_mode), 32'(ex), "conversion mode");
         apb(1'b0, aop_pkg::ADDR_STATUS, 32'h0);
         chk(32'(rdat[4:2]), 32'(ex), "status conversion mode");
      end
   endtask : test_conv

   // Bit 0 of the value is 0, so a misread coding pin would flip the MSB
   task automatic test_par(input logic [1:0] m, input logic code);
      logic [17:0] v, oe, ex;
      v = 18'h2a5c2;
      oe = (m == 2'h0) ? 18'h0 : 18'h7;
      ex = v ^ ((m != 2'h0 && !code) ? 18'h20000 : 18'h0);
      setup(m, {15'h0, 1'b0, 1'b1, code}, oe);
      apb(1'b1, aop_pkg::ADDR_RESULT, {14'h0, v});
      repeat (3) @(posedge pclk);
      chk(32'(pin_oe_n), 32'(oe), "parallel enables");
      chk(32'(pin_out & ~oe), 32'(ex & ~oe), "parallel data");
      apb(1'b0, aop_pkg::ADDR_STATUS, 32'h0);
      chk(32'(rdat[1:0]), 32'(m), "status mode");
      chk(32'(rdat[9]), 32'(m != 2'h0 && !code), "status coding");
      if (m != 2'h0) chk(32'(rdat[8:7]), 32'h1, "word select");
      apb(1'b0, aop_pkg::ADDR_RESULT, 32'h0);
      chk(rdat, {14'h0, v}, "result readback");
   endtask : test_par

   task automatic test_master(input logic [1:0] div, input logic pol, input logic read_during_conversion_sel);
      logic [17:0] v, d;
      int per, bad;
      v = 18'h2c71d ^ {16'h0, div};
      setup(2'h3, {8'h0, read_during_conversion_sel, 1'b0, pol, 1'b0, div, 4'h1}, 18'h003f7);
      chk(32'(pin_oe_n), 32'h3f3f7, "master enables");
      chk(32'(pin_out[3]), 32'h0, "always driven pin");
      chk(32'(frame_sync), 32'(pol), "sync idle");
      apb(1'b1, aop_pkg::ADDR_RESULT, {14'h0, v});
      apb(1'b1, aop_pkg::ADDR_CTRL, 32'h1);
      host.master_read(pol, d, per, bad);
      chk(32'(d), 32'(v), "master data");
      chk(per, read_during_conversion_sel ? 4 : 4 << div, "master clock period");
      chk(bad, 0, "sync active in frame");
      repeat (40) @(posedge pclk);
      chk(32'(frame_sync), 32'(pol), "sync after frame");
   endtask : test_master

   task automatic test_slave(input logic inv);
      logic [17:0] v, d;
      v = 18'h1e4b7;
      setup(2'h3, {9'h0, inv, 8'h40}, 18'h00bf7);
      chk(32'(pin_oe_n), 32'h3fbf7, "slave enables");
      apb(1'b1, aop_pkg::ADDR_RESULT, {14'h0, v});
      host.slave_read(inv, d);
      chk(32'(d), 32'(v ^ 18'h20000), "slave data");
   endtask : test_slave

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hf;
      mode_sel_pin = 2'h0;
      fast_mode_sel = 1'b0;
      accurate_mode_sel_n = 1'b1;
      cfg = 18'h0;
      host_en = 18'h0;
      repeat (3) @(posedge pclk);
      chk(32'(pin_oe_n), 32'(aop_pkg::OE_N_RST), "reset enables");
      @(posedge pclk);
      presetn <= 1'b1;
      test_conv();
      test_par(2'h0, 1'b1);
      test_par(2'h1, 1'b1);
      test_par(2'h1, 1'b0);
      test_par(2'h2, 1'b0);
      for (int i = 0; i < 4; i++) test_master(i[1:0], i[0], 1'b0);
      test_master(2'h3, 1'b0, 1'b1);
      test_slave(1'b0);
      test_slave(1'b1);
      apb(1'b0, 12'h00c, 32'h0);
      chk(32'(rerr), 32'h1, "unmapped error");
      chk(rdat, 32'h0, "unmapped data");
      stop_test();
   end
endmodule : testbench
